// ==== src/sba_top.sv ====
// Purpose: baud divider selection and arbiter / bit-time counter
// Assumes: one 100 MHz clock; receive pin asynchronous
// Notes:   rates are one-cycle enable pulses
`timescale 1ns/10ps
// Behaviour
// - all codes lowest gives bus clock divided by 64.
// - coarse prescale code selects divisor 1, 3, 4 or 13.
// - rate divider code divides further by 1 up to 128.
// - fine code 111 adds fraction/32 steps to a divide-by-eight.
// - overflow flag set on counter overflow, cleared by reset or control write.
// - nine-bit counter, msb in control, low eight in data register.
// - any control write or reset clears the counter.
// - mode field zero holds counter reset and idle.
// - clock select 0 counts at bus clock divided by four.
// - select 0 measurement runs between two receive falling edges.
// - running flag while counting, finished flag on second falling edge.
// - clock select 1 counts at half the prescaler output.
// - select 1 starts on low receive, immediately if already low.
// - select 1 stops on next receive rising edge.
// - mode 10 is arbitration, restart on each transmit rising edge.
// - arbitration samples receive at count 38h or 08h.
// - low sample sets arbitration lost flag.
// - while lost flag set, transmit pin forced to one.
module sba_top (
    input  wire logic clk_i,
    input  wire logic nrst_i,
    input  wire logic psel_i,
    input  wire logic penable_i,
    input  wire logic pwrite_i,
    input  wire logic [7:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input  wire logic rxd_i,
    input  wire logic internal_transmit_out_i,
    output logic txd_o,
    output logic baud_tick_o,
    output logic irq_o
);
    import sba_pkg::*;

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic       rst_n;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ------------------------------------------------------------
    // receive pin synchroniser
    // ------------------------------------------------------------
    logic [2:0] rx_sync_q;
    logic       rx_q, rx_d;
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rx_sync_q <= 3'b111;
            rx_q      <= 1'b1;
        end else begin
            rx_sync_q <= {rx_sync_q[1:0], rxd_i};
            rx_q      <= rx_d;
        end
    end
    always_comb begin
        rx_d = (rx_sync_q[1] == rx_sync_q[2]) ? rx_sync_q[2] : rx_q;
    end
    logic rx_fall, rx_rise;
    assign rx_fall = rx_q && !rx_d;
    assign rx_rise = !rx_q && rx_d;

    logic tx_prev_q;
    logic tx_rise;
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            tx_prev_q <= 1'b1;
        end else begin
            tx_prev_q <= internal_transmit_out_i;
        end
    end
    assign tx_rise = internal_transmit_out_i && !tx_prev_q;

    // ------------------------------------------------------------
    // registers and apb
    // ------------------------------------------------------------
    sba_baud_t          baud_q, baud_d;
    sba_actl_t          actl_q, actl_d;
    logic [IRQ_W-1:0]   ist_q, ist_d, imsk_q, imsk_d;
    logic [31:0]        rdata_d;
    logic               wr_acc, rd_acc, actl_wr, ist_rd, unmapped;
    logic [8:0]         cnt_q;
    logic               ovf_q, lost_q, fin_q;
    sba_state_t         st_q;
    logic               ev_fin, ev_lost, ev_ovf;

    assign wr_acc  = psel_i && penable_i && pwrite_i;
    assign rd_acc  = psel_i && penable_i && !pwrite_i;
    assign actl_wr = wr_acc && (paddr_i == OFF_ACTL);
    assign ist_rd  = rd_acc && (paddr_i == OFF_IRQ_ST);
    assign unmapped = !(paddr_i == OFF_BAUD || paddr_i == OFF_ACTL || paddr_i == OFF_ADAT
                        || paddr_i == OFF_IRQ_ST || paddr_i == OFF_IRQ_MSK);
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i && penable_i && unmapped;

    always_comb begin
        baud_d  = baud_q;
        actl_d  = actl_q;
        imsk_d  = imsk_q;
        rdata_d = 32'h0000_0000;
        if (wr_acc) begin
            case (paddr_i)
                OFF_BAUD:    baud_d = sba_baud_t'(pwdata_i[12:0]);
                OFF_ACTL:    actl_d = sba_actl_t'(pwdata_i[2:0]);
                OFF_IRQ_MSK: imsk_d = pwdata_i[IRQ_W-1:0];
                default:     ;
            endcase
        end
        case (paddr_i)
            OFF_BAUD:    rdata_d = {19'h0, baud_q};
            OFF_ACTL:    rdata_d = {24'h0, lost_q, fin_q, st_q == ST_RUN,
                                    cnt_q[8], ovf_q, actl_q};
            OFF_ADAT:    rdata_d = {24'h0, cnt_q[7:0]};
            OFF_IRQ_ST:  rdata_d = {29'h0, ist_q};
            OFF_IRQ_MSK: rdata_d = {29'h0, imsk_q};
            default:     rdata_d = 32'h0000_0000;
        endcase
        // hardware set wins over read clear
        ist_d = (ist_rd ? '0 : ist_q) | {ev_ovf, ev_lost, ev_fin};
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            baud_q   <= '0;
            actl_q   <= '0;
            imsk_q   <= '0;
            ist_q    <= '0;
            prdata_o <= 32'h0000_0000;
        end else begin
            baud_q <= baud_d;
            actl_q <= actl_d;
            imsk_q <= imsk_d;
            ist_q  <= ist_d;
            if (psel_i && !penable_i && !pwrite_i) begin
                prdata_o <= rdata_d;
            end
        end
    end
    assign irq_o = |(ist_q & imsk_q);

    // ------------------------------------------------------------
    // baud generator
    // ------------------------------------------------------------
    // base /64 in 1/32 steps: fraction adds f/32 to a /8 stage
    // 18 bits: coarse 13 with the fine fraction overflows 17
    logic [17:0] pre_div, pre_div_q;
    logic [17:0] pre_cnt_q, pre_cnt_d;
    logic        pre_tick;
    logic [6:0]  rate_cnt_q, rate_cnt_d;
    logic [7:0]  rate_div;
    always_comb begin
        pre_div = 18'(BASE_DIV * FRAC_STEPS);
        case (baud_q.coarse_prescale_code)
            2'b01:   pre_div = 18'(BASE_DIV * FRAC_STEPS * 3);
            2'b10:   pre_div = 18'(BASE_DIV * FRAC_STEPS * 4);
            2'b11:   pre_div = 18'(BASE_DIV * FRAC_STEPS * 13);
            default: pre_div = 18'(BASE_DIV * FRAC_STEPS);
        endcase
        if (baud_q.fine_prescale_code == 3'b111) begin
            pre_div = 18'(32'(pre_div) * (FRAC_DIV * FRAC_STEPS
                      + 32'(baud_q.prescale_fraction_field)) / FRAC_STEPS);
        end
        rate_div  = 8'(1 << baud_q.rate_divider_code);
        pre_cnt_d = pre_cnt_q + 18'(FRAC_STEPS);
        pre_tick  = 1'b0;
        if (pre_cnt_q + 18'(FRAC_STEPS) >= pre_div_q) begin
            pre_cnt_d = pre_cnt_q + 18'(FRAC_STEPS) - pre_div_q;
            pre_tick  = 1'b1;
        end
        rate_cnt_d = rate_cnt_q;
        if (pre_tick) begin
            rate_cnt_d = (8'(rate_cnt_q) + 8'h01 >= rate_div) ? 7'h00 : rate_cnt_q + 7'h01;
        end
    end
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pre_cnt_q   <= '0;
            pre_div_q   <= 18'(BASE_DIV * FRAC_STEPS);
            rate_cnt_q  <= '0;
            baud_tick_o <= 1'b0;
        end else begin
            pre_cnt_q   <= pre_cnt_d;
            pre_div_q   <= pre_div;
            rate_cnt_q  <= rate_cnt_d;
            baud_tick_o <= pre_tick && (8'(rate_cnt_q) + 8'h01 >= rate_div);
        end
    end

    // ------------------------------------------------------------
    // counter clock enables
    // ------------------------------------------------------------
    logic [1:0] div4_q;
    logic       half_q;
    logic       cnt_en;
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            div4_q <= '0;
            half_q <= 1'b0;
        end else begin
            div4_q <= div4_q + 2'h1;
            if (pre_tick) begin
                half_q <= !half_q;
            end
        end
    end
    assign cnt_en = actl_q.aclk_sel ? (pre_tick && half_q)
                                    : (div4_q == 2'(BUS_DIV4 - 1));

    // ------------------------------------------------------------
    // arbiter counter and measurement
    // ------------------------------------------------------------
    sba_state_t st_d;
    logic [8:0] cnt_d;
    logic       ovf_d, lost_d, fin_d, arb_mode, smp_pt;
    assign arb_mode = (actl_q.arbiter_mode_field == AM_ARB);
    assign smp_pt   = actl_q.aclk_sel ? (cnt_q == ARB_SAMPLE1) : (cnt_q == ARB_SAMPLE0);
    always_comb begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        ovf_d  = ovf_q;
        lost_d = lost_q;
        fin_d  = fin_q;
        ev_fin = 1'b0;
        ev_lost = 1'b0;
        ev_ovf = 1'b0;
        case (st_q)
            ST_IDLE: begin
                if (actl_q.arbiter_mode_field != AM_IDLE) begin
                    st_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (arb_mode) begin
                    if (tx_rise) begin
                        st_d  = ST_RUN;
                        cnt_d = '0;
                    end
                end else if (actl_q.aclk_sel ? !rx_q : rx_fall) begin
                    st_d  = ST_RUN;
                    cnt_d = '0;
                end
            end
            ST_RUN: begin
                if (arb_mode && tx_rise) begin
                    cnt_d = '0;
                end else if (!arb_mode && (actl_q.aclk_sel ? rx_rise : rx_fall)) begin
                    st_d   = ST_IDLE;
                    fin_d  = 1'b1;
                    ev_fin = 1'b1;
                end else if (cnt_en) begin
                    cnt_d = cnt_q + 9'h001;
                    if (cnt_q == '1) begin
                        ovf_d  = 1'b1;
                        ev_ovf = 1'b1;
                    end
                    if (arb_mode && smp_pt && !rx_q) begin
                        lost_d  = 1'b1;
                        ev_lost = 1'b1;
                    end
                end
            end
            default: st_d = ST_IDLE;
        endcase
        if (st_q == ST_IDLE && !fin_q && st_d != ST_IDLE) begin
            cnt_d = cnt_q;
        end
        if (actl_q.arbiter_mode_field == AM_IDLE) begin
            st_d  = ST_IDLE;
            cnt_d = '0;
        end
        if (actl_wr) begin
            st_d   = ST_IDLE;
            cnt_d  = '0;
            ovf_d  = 1'b0;
            fin_d  = 1'b0;
            lost_d = 1'b0;
        end
    end
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            st_q   <= ST_IDLE;
            cnt_q  <= '0;
            ovf_q  <= 1'b0;
            lost_q <= 1'b0;
            fin_q  <= 1'b0;
        end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            ovf_q  <= ovf_d;
            lost_q <= lost_d;
            fin_q  <= fin_d;
        end
    end
    // a finished measurement passes through idle back to wait; the count holds until the next start
    assign txd_o = lost_q ? 1'b1 : internal_transmit_out_i;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_tx_forced: assert property (@(posedge clk_i) disable iff (!rst_n)
        lost_q |-> txd_o) else $error("transmit not forced while lost");
    a_wr_clears: assert property (@(posedge clk_i) disable iff (!rst_n)
        actl_wr |=> (cnt_q == 9'h000 && !ovf_q)) else $error("control write no clear");
    a_idle_hold: assert property (@(posedge clk_i) disable iff (!rst_n)
        (actl_q.arbiter_mode_field == AM_IDLE) |=> cnt_q == 9'h000)
        else $error("idle counter not zero");
    a_ovf_set: assert property (@(posedge clk_i) disable iff (!rst_n)
        (st_q == ST_RUN && cnt_en && cnt_q == 9'h1FF && !actl_wr && !tx_rise
         && !rx_fall && !rx_rise && actl_q.arbiter_mode_field != AM_IDLE) |=> ovf_q)
        else $error("overflow flag missed");
    a_div4_rate: assert property (@(posedge clk_i) disable iff (!rst_n)
        (!actl_q.aclk_sel && cnt_en) |=> !cnt_en [*3]) else $error("div4 rate wrong");
    a_lost_set: assert property (@(posedge clk_i) disable iff (!rst_n)
        (st_q == ST_RUN && arb_mode && cnt_en && smp_pt && !rx_q && !tx_rise && !actl_wr)
        |=> lost_q) else $error("lost flag missed");
    a_fin_set: assert property (@(posedge clk_i) disable iff (!rst_n)
        (st_q == ST_RUN && !arb_mode && !actl_q.aclk_sel && rx_fall && !actl_wr
         && actl_q.arbiter_mode_field != AM_IDLE) |=> (fin_q && st_q == ST_IDLE))
        else $error("finish not flagged");
    a_irq_level: assert property (@(posedge clk_i) disable iff (!rst_n)
        irq_o == |(ist_q & imsk_q)) else $error("irq level wrong");
endmodule

// ==== src/sba_pkg.sv ====
// Purpose: shared constants and types for the serial baud and bus arbiter block
// Assumes: 32-bit APB, one word per register
// Notes:   offsets chosen locally, see hand-over
package sba_pkg;
    localparam logic [7:0] OFF_BAUD    = 8'h00;
    localparam logic [7:0] OFF_ACTL    = 8'h04;
    localparam logic [7:0] OFF_ADAT    = 8'h08;
    localparam logic [7:0] OFF_IRQ_ST  = 8'h0C;
    localparam logic [7:0] OFF_IRQ_MSK = 8'h10;
    localparam int         BASE_DIV    = 64;
    localparam int         FRAC_DIV    = 8;
    localparam int         FRAC_STEPS  = 32;
    localparam int         BUS_DIV4    = 4;
    localparam logic [8:0] ARB_SAMPLE0 = 9'h038;
    localparam logic [8:0] ARB_SAMPLE1 = 9'h008;
    localparam logic [1:0] AM_IDLE     = 2'b00;
    localparam logic [1:0] AM_ARB      = 2'b10;
    localparam int         IRQ_W       = 3;
    localparam int         IRQ_FIN     = 0;
    localparam int         IRQ_LOST    = 1;
    localparam int         IRQ_OVF     = 2;

    typedef struct packed {
        logic [2:0] fine_prescale_code;
        logic [4:0] prescale_fraction_field;
        logic [1:0] coarse_prescale_code;
        logic [2:0] rate_divider_code;
    } sba_baud_t;

    typedef struct packed {
        logic [1:0] arbiter_mode_field;
        logic       aclk_sel;
    } sba_actl_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_RUN  = 3'b100
    } sba_state_t;
endpackage

// ==== test/sba_partner.sv ====
// Purpose: another node sharing the serial line
// Assumes: wired-and line with pull-up, low is dominant
// Notes:   dom() changes the drive just after a clock edge
`timescale 1ns/10ps
module sba_partner (
    input  wire logic clk_i,
    input  wire logic txd_i,
    output logic      line_o
);
    logic dom_q;

    initial begin
        dom_q <= 1'b0;
    end

    task automatic dom(input logic d);
        @(posedge clk_i);
        dom_q <= d;
    endtask

    // released line follows the transmit output of the block
    assign line_o = txd_i & ~dom_q;
endmodule

// ==== test/tb_sba_top.sv ====
// Purpose: self-checking bench for the baud and arbiter block
// Assumes: zero wait APB, receive pin fed from a wired-and line
// Notes:   counts allow one count of slack for sync delay
`timescale 1ns/10ps
module tb_sba_top;
    import sba_pkg::*;
    logic        clk_i;
    logic        nrst_i;
    logic        psel_i;
    logic        penable_i;
    logic        pwrite_i;
    logic [7:0]  paddr_i;
    logic [31:0] pwdata_i;
    logic        tx_i;
    logic [31:0] prdata_o, r, c1;
    logic        pready_o, pslverr_o, txd_o, baud_tick_o, irq_o, line;
    logic [33:0] exp_q[$];
    logic [33:0] e;
    logic [12:0] cfg_a[7] = '{13'h0000, 13'h0008, 13'h0011, 13'h0018,
                              13'h0007, 13'h1C00, 13'h1FE0};
    int          per_a[7] = '{64, 192, 512, 832, 8192, 512, 574};
    int          n_mismatch = 0, cmp_count = 0, cyc = 0, seed = 65, p, n;
    time         t0;

    sba_top sba_top_inst (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .rxd_i(line), .internal_transmit_out_i(tx_i),
        .txd_o(txd_o), .baud_tick_o(baud_tick_o), .irq_o(irq_o));
    sba_partner sba_partner_inst (.clk_i(clk_i), .txd_i(txd_o), .line_o(line));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic check(input logic [33:0] seen, input logic [33:0] expv);
        cmp_count++;
        if (seen !== expv) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask

    task automatic final_report;
        $display("compares=%0d mismatches=%0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // read results checked against the oldest note
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 95000) begin
            n_mismatch++;
            final_report();
        end
        if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            if (e[33]) check({1'b1, pslverr_o, prdata_o}, e);
        end
    end

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [33:0] x, output logic [31:0] rv);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= w ? d : $random(seed);
        if (!w) exp_q.push_back(x);
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        rv = prdata_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 34'h0, r);
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] x);
        apb(1'b0, a, 32'h0, {1'b1, x}, r);
    endtask
    task automatic rdx(input logic [7:0] a);
        apb(1'b0, a, 32'h0, 34'h0, r);
    endtask
    task automatic wt(input int k);
        repeat (k) @(posedge clk_i);
    endtask
    task automatic tick;
        do @(posedge clk_i); while (baud_tick_o !== 1'b1);
    endtask

    initial begin
        nrst_i    <= 1'b0;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        pwrite_i  <= 1'b0;
        paddr_i   <= 8'h00;
        pwdata_i  <= $random(seed);
        tx_i      <= 1'b1;
        wt(20);
        nrst_i <= 1'b1;
        wt(3);
        for (int i = 0; i < 5; i++) rd(8'(4 * i), 33'h0);
        rd(8'h14, 33'h100000000);
        // ---------------------------------------
        // baud divider table
        // ---------------------------------------
        for (int i = 0; i < 7; i++) begin
            wr(OFF_BAUD, {19'h0, cfg_a[i]});
            rd(OFF_BAUD, {14'h0, 6'h0, cfg_a[i]});
            n = (i == 6) ? 32 : 2;
            tick();
            t0 = $time;
            repeat (n) tick();
            check(34'(($time - t0) / 10), 34'(n * per_a[i]));
        end
        // ---------------------------------------
        // falling-edge bit time, select 0
        // ---------------------------------------
        p = 1100 + 4 * ($random(seed) & 63);
        wr(OFF_ACTL, 32'h2);
        sba_partner_inst.dom(1'b1);
        t0 = $time;
        wt(10);
        sba_partner_inst.dom(1'b0);
        rdx(OFF_ACTL);
        check(34'(r[5]), 34'h1);
        wt(int'(p - 1 - ($time - t0) / 10));
        sba_partner_inst.dom(1'b1);
        wt(10);
        sba_partner_inst.dom(1'b0);
        wt(10);
        rd(OFF_ACTL, 33'h052);
        rdx(OFF_ADAT);
        check(34'((r + 256) - p / 4 + 1 <= 2), 34'h1);
        check(34'(irq_o), 34'h0);
        wr(OFF_IRQ_MSK, 32'h7);
        wt(1);
        check(34'(irq_o), 34'h1);
        rd(OFF_IRQ_ST, 33'h1);
        wt(1);
        check(34'(irq_o), 34'h0);
        rd(OFF_IRQ_ST, 33'h0);
        wr(OFF_ACTL, 32'h2);
        rd(OFF_ACTL, 33'h002);
        rd(OFF_ADAT, 33'h0);
        // ---------------------------------------
        // overflow, then clear by control write
        // ---------------------------------------
        sba_partner_inst.dom(1'b1);
        wt(2100);
        rd(OFF_ACTL, 33'h02A);
        wr(OFF_ACTL, 32'h2);
        rd(OFF_ACTL, 33'h002);
        rd(OFF_IRQ_ST, 33'h4);
        sba_partner_inst.dom(1'b0);
        // ---------------------------------------
        // idle mode holds the counter
        // ---------------------------------------
        wr(OFF_ACTL, 32'h0);
        sba_partner_inst.dom(1'b1);
        wt(20);
        sba_partner_inst.dom(1'b0);
        wt(20);
        rd(OFF_ADAT, 33'h0);
        rd(OFF_ACTL, 33'h0);
        // ---------------------------------------
        // break length, select 1, line already low
        // ---------------------------------------
        wr(OFF_BAUD, 32'h0);
        sba_partner_inst.dom(1'b1);
        wt(10);
        wr(OFF_ACTL, 32'h3);
        wt(300);
        rdx(OFF_ACTL);
        check(34'(r[5]), 34'h1);
        sba_partner_inst.dom(1'b0);
        wt(20);
        rdx(OFF_ADAT);
        c1 = r;
        check(34'(c1 != 0), 34'h1);
        wt(100);
        rd(OFF_ADAT, {1'b0, c1});
        rd(OFF_ACTL, 33'h043);
        rdx(OFF_IRQ_ST);
        // ---------------------------------------
        // arbitration lost against a dominant node
        // ---------------------------------------
        wr(OFF_ACTL, 32'h4);
        tx_i <= 1'b0;
        sba_partner_inst.dom(1'b1);
        @(posedge clk_i) tx_i <= 1'b1;
        wt(150);
        rdx(OFF_ACTL);
        check(34'(r[7]), 34'h0);
        wt(150);
        rdx(OFF_ACTL);
        check(34'(r[7]), 34'h1);
        @(posedge clk_i) tx_i <= 1'b0;
        wt(2);
        check(34'(txd_o), 34'h1);
        rd(OFF_IRQ_ST, 33'h2);
        sba_partner_inst.dom(1'b0);
        wr(OFF_ACTL, 32'h4);
        wt(1);
        check(34'(txd_o), 34'h0);
        // restart on each transmit rising edge
        @(posedge clk_i) tx_i <= 1'b1;
        wt(100);
        rdx(OFF_ADAT);
        c1 = r;
        @(posedge clk_i) tx_i <= 1'b0;
        wt(3);
        @(posedge clk_i) tx_i <= 1'b1;
        wt(20);
        rdx(OFF_ADAT);
        check(34'(r < c1 && c1 > 20), 34'h1);
        wt(250);
        rdx(OFF_ACTL);
        check(34'(r[7]), 34'h0);
        final_report();
    end
endmodule
